// *** logic/pnb_top.sv ***
// pnb_top: scan datapath for sign inversion, binary/decimal conversion and
// signed 32-bit compare contacts. Requests come one per cycle from the scan
// sequencer on the same clock; answers appear one cycle later.
//
// Functional notes
// - sign inversion writes the two's-complement negation of the 16-bit destination value back.
// - binary-to-decimal turns a value 0 to 9999 into four packed decimal digits.
// - decimal-to-binary turns four packed decimal digits 0 to 9999 into a binary integer.
// - the 32-bit compare treats both operands as signed, bit 31 set meaning negative.
// - there are six relations each in load, series and parallel form, 18 variants.
// - a compare acts as a normally open contact that conducts only when its relation holds.
// - load and parallel forms are evaluated every scan and combine like plain contacts.
// - the series form is evaluated only when the preceding rung state is on and is ANDed with it.
// - a bit-device digit unit selects four bits from bit 0 upward, four units giving 16 bits.
// - for 32-bit operands up to eight units select bits 0 to 31.
`timescale 1ns/1ns
module pnb_top #(
  parameter int SLOTS = 16,
  parameter int SLOT_W = 4
) (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic OP_VALID,
  input wire pnb_pkg::pnb_op_t OP_CODE,
  input wire logic [SLOT_W-1:0] OP_SLOT,
  input wire logic EXEC_COND,
  input wire pnb_pkg::pnb_rel_t CMP_REL,
  input wire pnb_pkg::pnb_form_t CMP_FORM,
  input wire logic RUNG_IN,
  input wire pnb_pkg::pnb_src_t A_KIND,
  input wire logic [15:0] A_WORD_LO,
  input wire logic [15:0] A_WORD_HI,
  input wire logic [31:0] A_BITS,
  input wire logic [3:0] A_DIGITS,
  input wire logic [31:0] A_CONST,
  input wire pnb_pkg::pnb_src_t B_KIND,
  input wire logic [15:0] B_WORD_LO,
  input wire logic [15:0] B_WORD_HI,
  input wire logic [31:0] B_BITS,
  input wire logic [3:0] B_DIGITS,
  input wire logic [31:0] B_CONST,
  output logic DONE,
  output logic DEST_WE,
  output logic [15:0] DEST_DATA,
  output logic RUNG_OUT,
  output logic CMP_HIT,
  output logic OP_ERR
);
  import pnb_pkg::*;

  // ==========================================================================
  // parameter checks
  if (SLOTS < 1 || SLOTS > (1 << SLOT_W)) begin : g_bad_slots
    $error("SLOTS must be 1 to 2**SLOT_W");
  end

  // ==========================================================================
  // helpers
  function automatic logic [15:0] to_dec(input logic [15:0] v);
    logic [31:0] sh;
    sh = {16'h0000, v};
    for (int i = 0; i < 16; i++) begin
      for (int d = 0; d < 4; d++) begin
        if (sh[16 + d*4 +: 4] > 4'h4) begin
          sh[16 + d*4 +: 4] = sh[16 + d*4 +: 4] + 4'h3;
        end
      end
      sh = sh << 1;
    end
    return sh[31:16];
  endfunction

  function automatic logic [15:0] from_dec(input logic [15:0] v);
    return 16'(v[15:12] * 1000) + 16'(v[11:8] * 100) + 16'(v[7:4] * 10) + 16'(v[3:0]);
  endfunction

  function automatic logic rel_holds(input pnb_rel_t r, input logic [31:0] a,
                                     input logic [31:0] b);
    logic lt;
    logic eq;
    lt = $signed(a) < $signed(b);
    eq = a == b;
    case (r)
      REL_EQ: return eq;
      REL_NE: return !eq;
      REL_GT: return !lt && !eq;
      REL_LE: return lt || eq;
      REL_LT: return lt;
      REL_GE: return !lt;
      default: return 1'b0;
    endcase
  endfunction

  // ==========================================================================
  // operands
  logic [31:0] a_opnd;
  logic [31:0] b_opnd;
  logic a_err;
  logic b_err;
  logic is_cmp;

  assign is_cmp = OP_CODE == OP_CMP;

  pnb_opnd_sel u_sel_a (
    .kind(A_KIND),
    .wide(is_cmp),
    .word_lo(A_WORD_LO),
    .word_hi(A_WORD_HI),
    .bits(A_BITS),
    .digits(A_DIGITS),
    .const_val(A_CONST),
    .opnd(a_opnd),
    .err(a_err)
  );

  pnb_opnd_sel u_sel_b (
    .kind(B_KIND),
    .wide(1'b1),
    .word_lo(B_WORD_LO),
    .word_hi(B_WORD_HI),
    .bits(B_BITS),
    .digits(B_DIGITS),
    .const_val(B_CONST),
    .opnd(b_opnd),
    .err(b_err)
  );

  // ==========================================================================
  // state
  logic prev_cond_r [SLOTS];
  logic done_r, done_nxt;
  logic we_r, we_nxt;
  logic [15:0] data_r, data_nxt;
  logic rung_r, rung_nxt;
  logic hit_r, hit_nxt;
  logic err_r, err_nxt;
  logic slot_we;
  logic prev_hit;
  logic [15:0] a16;

  assign a16 = a_opnd[15:0];
  assign prev_hit = prev_cond_r[OP_SLOT];

  // next values; each instruction slot keeps its own last condition
  always_comb begin
    logic is_pulse;
    logic run;
    logic opnd_bad;
    logic h;
    is_pulse = OP_CODE inside {OP_SIGN_INV_P, OP_BIN2DEC_P, OP_DEC2BIN_P};
    run = EXEC_COND && !(is_pulse && prev_hit);
    opnd_bad = a_err || (is_cmp && b_err);
    h = 1'b0;
    slot_we = OP_VALID && is_pulse;
    done_nxt = OP_VALID;
    we_nxt = 1'b0;
    data_nxt = data_r;
    rung_nxt = rung_r;
    hit_nxt = hit_r;
    err_nxt = 1'b0;
    if (OP_VALID) begin
      case (OP_CODE)
        OP_SIGN_INV, OP_SIGN_INV_P: begin
          if (run && !opnd_bad) begin
            we_nxt = 1'b1;
            data_nxt = 16'(~a16 + 16'h0001);
          end
          err_nxt = run && opnd_bad;
        end
        OP_BIN2DEC, OP_BIN2DEC_P: begin
          // above 9999 the digits cannot represent it: flag, keep destination
          if (run && !opnd_bad && a16 <= DEC_MAX) begin
            we_nxt = 1'b1;
            data_nxt = to_dec(a16);
          end
          err_nxt = run && (opnd_bad || a16 > DEC_MAX);
        end
        OP_DEC2BIN, OP_DEC2BIN_P: begin
          if (run && !opnd_bad && a16[15:12] <= NIB_MAX && a16[11:8] <= NIB_MAX &&
              a16[7:4] <= NIB_MAX && a16[3:0] <= NIB_MAX) begin
            we_nxt = 1'b1;
            data_nxt = from_dec(a16);
          end else begin
            err_nxt = run;
          end
        end
        OP_CMP: begin
          h = rel_holds(CMP_REL, a_opnd, b_opnd) && !opnd_bad;
          err_nxt = opnd_bad;
          case (CMP_FORM)
            FORM_LOAD: begin
              hit_nxt = h;
              rung_nxt = h;
            end
            FORM_SERIES: begin
              // skipped when the rung is already off; the contact then reads open
              hit_nxt = RUNG_IN && h;
              rung_nxt = RUNG_IN && h;
            end
            FORM_PARALLEL: begin
              hit_nxt = h;
              rung_nxt = RUNG_IN || h;
            end
            default: begin
              hit_nxt = 1'b0;
              err_nxt = 1'b1;
            end
          endcase
        end
        default: begin
          err_nxt = OP_CODE != OP_NOP;
        end
      endcase
    end
  end

  // registers; the slot memory only remembers pulse-variant conditions
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      for (int i = 0; i < SLOTS; i++) begin
        prev_cond_r[i] <= 1'b0;
      end
      done_r <= 1'b0;
      we_r <= 1'b0;
      data_r <= DATA_RST;
      rung_r <= 1'b0;
      hit_r <= 1'b0;
      err_r <= 1'b0;
    end else begin
      if (slot_we) begin
        prev_cond_r[OP_SLOT] <= EXEC_COND;
      end
      done_r <= done_nxt;
      we_r <= we_nxt;
      data_r <= data_nxt;
      rung_r <= rung_nxt;
      hit_r <= hit_nxt;
      err_r <= err_nxt;
    end
  end

  assign DONE = done_r;
  assign DEST_WE = we_r;
  assign DEST_DATA = data_r;
  assign RUNG_OUT = rung_r;
  assign CMP_HIT = hit_r;
  assign OP_ERR = err_r;

  // ==========================================================================
  // assertions
  logic a_eq_b;
  assign a_eq_b = a_opnd == b_opnd;

  property p_neg;
    @(posedge CLK_SYS) disable iff (!RST_N)
    OP_VALID && OP_CODE == OP_SIGN_INV && EXEC_COND && !a_err
      |=> DEST_WE && DEST_DATA + $past(a16) == 16'h0000;
  endproperty
  a_neg: assert property (p_neg) else $error("negation result wrong");

  property p_b2d;
    @(posedge CLK_SYS) disable iff (!RST_N)
    OP_VALID && OP_CODE == OP_BIN2DEC && EXEC_COND && !a_err && a16 <= DEC_MAX
      |=> DEST_WE && from_dec(DEST_DATA) == $past(a16);
  endproperty
  a_b2d: assert property (p_b2d) else $error("decimal code wrong");

  property p_d2b;
    @(posedge CLK_SYS) disable iff (!RST_N)
    OP_VALID && OP_CODE == OP_DEC2BIN && EXEC_COND && !a_err && a16 == 16'h9999
      |=> DEST_WE && DEST_DATA == DEC_MAX;
  endproperty
  a_d2b: assert property (p_d2b) else $error("binary from decimal wrong");

  property p_signed;
    @(posedge CLK_SYS) disable iff (!RST_N)
    OP_VALID && is_cmp && CMP_FORM == FORM_LOAD && CMP_REL == REL_LT &&
      a_opnd[31] && !b_opnd[31] && !a_err && !b_err |=> CMP_HIT;
  endproperty
  a_signed: assert property (p_signed) else $error("negative not below positive");

  property p_eq_contact;
    @(posedge CLK_SYS) disable iff (!RST_N)
    OP_VALID && is_cmp && CMP_FORM == FORM_LOAD && CMP_REL == REL_EQ && !a_err && !b_err
      |=> CMP_HIT == $past(a_eq_b) && RUNG_OUT == CMP_HIT;
  endproperty
  a_eq_contact: assert property (p_eq_contact) else $error("equal contact wrong");

  property p_parallel;
    @(posedge CLK_SYS) disable iff (!RST_N)
    OP_VALID && is_cmp && CMP_FORM == FORM_PARALLEL |=> RUNG_OUT == ($past(RUNG_IN) || CMP_HIT);
  endproperty
  a_parallel: assert property (p_parallel) else $error("parallel form wrong");

  property p_series;
    @(posedge CLK_SYS) disable iff (!RST_N)
    OP_VALID && is_cmp && CMP_FORM == FORM_SERIES && !RUNG_IN |=> !CMP_HIT && !RUNG_OUT;
  endproperty
  a_series: assert property (p_series) else $error("series form conducted");

  property p_pulse_once;
    @(posedge CLK_SYS) disable iff (!RST_N)
    OP_VALID && OP_CODE == OP_SIGN_INV_P && EXEC_COND
      ##1 OP_VALID && OP_CODE == OP_SIGN_INV_P && EXEC_COND && OP_SLOT == $past(OP_SLOT)
      |=> !DEST_WE;
  endproperty
  a_pulse_once: assert property (p_pulse_once) else $error("pulse op ran twice");

  property p_digit_one;
    @(posedge CLK_SYS) disable iff (!RST_N)
    OP_VALID && OP_CODE == OP_SIGN_INV && EXEC_COND && A_KIND == SRC_BITS && A_DIGITS == 4'h1
      |=> DEST_WE && DEST_DATA == 16'(-{12'h000, $past(A_BITS[3:0])});
  endproperty
  a_digit_one: assert property (p_digit_one) else $error("one digit unit wrong");

  property p_wide_pair;
    @(posedge CLK_SYS) disable iff (!RST_N)
    OP_VALID && is_cmp && CMP_FORM == FORM_LOAD && CMP_REL == REL_EQ && A_KIND == SRC_WORD &&
      B_KIND == SRC_BITS && B_DIGITS == 4'h8
      |=> CMP_HIT == ($past({A_WORD_HI, A_WORD_LO}) == $past(B_BITS));
  endproperty
  a_wide_pair: assert property (p_wide_pair) else $error("wide operand forming wrong");

  c_series_hit: cover property (@(posedge CLK_SYS) disable iff (!RST_N)
    OP_VALID && is_cmp && CMP_FORM == FORM_SERIES ##1 CMP_HIT);
  c_b2d_write: cover property (@(posedge CLK_SYS) disable iff (!RST_N)
    OP_VALID && OP_CODE == OP_BIN2DEC_P ##1 DEST_WE);
  c_range_err: cover property (@(posedge CLK_SYS) disable iff (!RST_N)
    OP_VALID && OP_CODE == OP_BIN2DEC ##1 OP_ERR);

endmodule

// *** logic/pnb_pkg.sv ***
// pnb_pkg: constants and types shared by the scan-instruction datapath.
// Assumes a single scan clock domain. The package itself holds no logic.
package pnb_pkg;

  // ==========================================================================
  // widths
  localparam int DATA_W = 16;
  localparam int OPND_W = 32;
  localparam int NIB_W = 4;
  localparam int DIGIT_CNT_W = 4;
  localparam logic [3:0] DIGITS_MAX_16 = 4'h4; // digit_group_four
  localparam logic [3:0] DIGITS_MAX_32 = 4'h8; // digit_group_eight
  localparam logic [3:0] DIGITS_MIN = 4'h1; // digit_group_one

  // ==========================================================================
  // decimal range
  localparam logic [15:0] DEC_MAX = 16'h270F; // 9999
  localparam logic [3:0] NIB_MAX = 4'h9;

  // ==========================================================================
  // reset values
  localparam logic [15:0] DATA_RST = 16'h0000;

  // ==========================================================================
  // instruction codes
  typedef enum logic [3:0] {
    OP_NOP        = 4'h0,
    OP_SIGN_INV   = 4'h1, // sign_invert_op
    OP_SIGN_INV_P = 4'h2, // sign_invert_pulse_op
    OP_BIN2DEC    = 4'h3,
    OP_BIN2DEC_P  = 4'h4, // bin_to_decimal_pulse_op
    OP_DEC2BIN    = 4'h5,
    OP_DEC2BIN_P  = 4'h6, // decimal_to_bin_pulse_op
    OP_CMP        = 4'h7
  } pnb_op_t;

  typedef enum logic [2:0] {
    REL_EQ = 3'h0,
    REL_NE = 3'h1,
    REL_GT = 3'h2,
    REL_LE = 3'h3,
    REL_LT = 3'h4,
    REL_GE = 3'h5
  } pnb_rel_t;

  // load_contact, series and parallel forms
  typedef enum logic [1:0] {
    FORM_LOAD     = 2'h0,
    FORM_SERIES   = 2'h1,
    FORM_PARALLEL = 2'h2
  } pnb_form_t;

  typedef enum logic [1:0] {
    SRC_WORD  = 2'h0,
    SRC_BITS  = 2'h1,
    SRC_CONST = 2'h2
  } pnb_src_t;

endpackage

// *** logic/pnb_opnd_sel.sv ***
// pnb_opnd_sel: forms one operand from a word pair, bit-device digit groups
// or a constant. Purely combinational; the caller registers the results.
`timescale 1ns/1ns
module pnb_opnd_sel
  import pnb_pkg::*;
(
  input wire pnb_pkg::pnb_src_t kind,
  input wire logic wide,
  input wire logic [15:0] word_lo,
  input wire logic [15:0] word_hi,
  input wire logic [31:0] bits,
  input wire logic [3:0] digits,
  input wire logic [31:0] const_val,
  output logic [31:0] opnd,
  output logic err
);

  // ==========================================================================
  // digit mask: each unit takes four more bits from bit 0 upward
  function automatic logic [31:0] digit_mask(input logic [3:0] n);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int i = 0; i < 8; i++) begin
      if (4'(i) < n) begin
        m[i*4 +: 4] = 4'hF;
      end
    end
    return m;
  endfunction

  // ==========================================================================
  // source select; narrow ops look only at the low word
  always_comb begin
    logic [3:0] lim;
    lim = wide ? DIGITS_MAX_32 : DIGITS_MAX_16;
    err = 1'b0;
    opnd = 32'h0000_0000;
    case (kind)
      SRC_WORD: begin
        opnd = wide ? {word_hi, word_lo} : {16'h0000, word_lo};
      end
      SRC_BITS: begin
        // out-of-range unit counts are flagged, never silently clipped
        err = (digits < DIGITS_MIN) || (digits > lim);
        opnd = bits & digit_mask(digits);
      end
      SRC_CONST: begin
        opnd = wide ? const_val : {16'h0000, const_val[15:0]};
      end
      default: begin
        err = 1'b1;
      end
    endcase
  end

endmodule

// *** tb/tb_pnb_top.sv ***
// tb_pnb_top: self-checking bench for the scan datapath with a reference model.
// Assumes pnb_pkg and the design files are compiled first; one 20 MHz clock.
`timescale 1ns/1ns
module tb_pnb_top;
  import pnb_pkg::*;
  // ==========================================================================
  // stimulus, outputs and model state
  logic CLK_SYS = 1'b0;
  logic RST_N = 1'b0;
  logic OP_VALID = 1'b0;
  pnb_op_t OP_CODE = OP_NOP;
  logic [3:0] OP_SLOT = 4'h0;
  logic EXEC_COND = 1'b0;
  pnb_rel_t CMP_REL = REL_EQ;
  pnb_form_t CMP_FORM = FORM_LOAD;
  logic RUNG_IN = 1'b0;
  pnb_src_t A_KIND = SRC_WORD;
  pnb_src_t B_KIND = SRC_WORD;
  logic [15:0] A_WORD_LO = 16'h0000;
  logic [15:0] A_WORD_HI = 16'h0000;
  logic [15:0] B_WORD_LO = 16'h0000;
  logic [15:0] B_WORD_HI = 16'h0000;
  logic [31:0] A_BITS = 32'h00000000;
  logic [31:0] B_BITS = 32'h00000000;
  logic [31:0] A_CONST = 32'h00000000;
  logic [31:0] B_CONST = 32'h00000000;
  logic [3:0] A_DIGITS = 4'h4;
  logic [3:0] B_DIGITS = 4'h8;
  logic DONE;
  logic DEST_WE;
  logic [15:0] DEST_DATA;
  logic RUNG_OUT;
  logic CMP_HIT;
  logic OP_ERR;
  int miscompares = 0;
  int cmp_count = 0;
  logic [15:0] m_data;
  logic m_rung;
  logic m_hit;
  logic [15:0] m_slot;
  logic [15:0] vals [8] = '{16'h0005, 16'h0000, 16'h8000, 16'h7FFF,
                           16'hFFFF, 16'h270F, 16'h2710, 16'h9999};
  logic [31:0] edge_a [4] = '{32'h80000000, 32'h80000000, 32'h7FFFFFFF, 32'h12345678};
  logic [31:0] edge_b [4] = '{32'h00000001, 32'h80000001, 32'h80000000, 32'h12345678};

  pnb_top #(.SLOTS(16), .SLOT_W(4)) u_dut (
    .CLK_SYS(CLK_SYS), .RST_N(RST_N), .OP_VALID(OP_VALID), .OP_CODE(OP_CODE),
    .OP_SLOT(OP_SLOT), .EXEC_COND(EXEC_COND), .CMP_REL(CMP_REL), .CMP_FORM(CMP_FORM),
    .RUNG_IN(RUNG_IN), .A_KIND(A_KIND), .A_WORD_LO(A_WORD_LO), .A_WORD_HI(A_WORD_HI),
    .A_BITS(A_BITS), .A_DIGITS(A_DIGITS), .A_CONST(A_CONST), .B_KIND(B_KIND),
    .B_WORD_LO(B_WORD_LO), .B_WORD_HI(B_WORD_HI), .B_BITS(B_BITS), .B_DIGITS(B_DIGITS),
    .B_CONST(B_CONST), .DONE(DONE), .DEST_WE(DEST_WE), .DEST_DATA(DEST_DATA),
    .RUNG_OUT(RUNG_OUT), .CMP_HIT(CMP_HIT), .OP_ERR(OP_ERR)
  );

  // scan clock, 50 ns period
  always #25 CLK_SYS = ~CLK_SYS;

  // ==========================================================================
  // shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: op %0d seen %h expected %h", $time, OP_CODE, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("compares %0d, miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // operand former model: {error, value}; bit operands are zero-extended
  function automatic logic [32:0] form(pnb_src_t k, logic w, logic [15:0] lo, logic [15:0] hi,
                                       logic [31:0] bits, logic [3:0] d, logic [31:0] c);
    logic [31:0] v;
    logic e;
    v = 32'h00000000;
    e = 1'b0;
    case (k)
      SRC_WORD: v = w ? {hi, lo} : {16'h0000, lo};
      SRC_BITS: begin
        e = (d == 4'h0) || (d > (w ? DIGITS_MAX_32 : DIGITS_MAX_16));
        for (int i = 0; i < 32; i++) if (i < 4 * d) v[i] = bits[i];
      end
      SRC_CONST: v = w ? c : {16'h0000, c[15:0]};
      default: e = 1'b1;
    endcase
    return {e, v};
  endfunction

  // presents one request at the next edge and compares the answer a cycle later
  task automatic run();
    logic [32:0] a;
    logic [32:0] b;
    logic hit;
    logic we;
    logic err;
    logic doit;
    logic [15:0] res;
    int sa;
    int sb;
    int v;
    a = form(A_KIND, OP_CODE == OP_CMP, A_WORD_LO, A_WORD_HI, A_BITS, A_DIGITS, A_CONST);
    b = form(B_KIND, 1'b1, B_WORD_LO, B_WORD_HI, B_BITS, B_DIGITS, B_CONST);
    we = 1'b0;
    err = a[32];
    doit = EXEC_COND;
    if (OP_CODE inside {OP_SIGN_INV_P, OP_BIN2DEC_P, OP_DEC2BIN_P}) begin
      doit = EXEC_COND && !m_slot[OP_SLOT];
      m_slot[OP_SLOT] = EXEC_COND;
    end
    if (OP_CODE == OP_CMP) begin
      sa = a[31:0];
      sb = b[31:0];
      case (CMP_REL)
        REL_EQ: hit = sa == sb;
        REL_NE: hit = sa != sb;
        REL_GT: hit = sa > sb;
        REL_LE: hit = sa <= sb;
        REL_LT: hit = sa < sb;
        default: hit = sa >= sb;
      endcase
      err = a[32] | b[32];
      hit = hit & ~err;
      if (CMP_FORM == FORM_SERIES) hit = hit & RUNG_IN;
      m_hit = hit;
      m_rung = (CMP_FORM == FORM_PARALLEL) ? (RUNG_IN | hit) : hit;
    end else if (doit) begin
      v = a[15:0];
      res = ~a[15:0] + 16'h0001;
      if (OP_CODE inside {OP_BIN2DEC, OP_BIN2DEC_P}) begin
        err |= v > 9999;
        res = 16'(((v / 1000) << 12) | ((v / 100 % 10) << 8) | ((v / 10 % 10) << 4) | (v % 10));
      end else if (OP_CODE inside {OP_DEC2BIN, OP_DEC2BIN_P}) begin
        for (int n = 0; n < 4; n++) if (a[4 * n +: 4] > NIB_MAX) err = 1'b1;
        res = 16'(a[15:12] * 1000 + a[11:8] * 100 + a[7:4] * 10 + a[3:0]);
      end
      we = !err;
      if (we) m_data = res;
    end else begin
      err = 1'b0;
    end
    OP_VALID = 1'b1;
    @(negedge CLK_SYS);
    check(DONE, 1);
    check(DEST_WE, we);
    check(DEST_DATA, m_data);
    check(CMP_HIT, m_hit);
    check(RUNG_OUT, m_rung);
    check(OP_ERR, err);
  endtask

  task automatic rnd_opnds(input logic wide);
    A_KIND = pnb_src_t'($urandom_range(2));
    B_KIND = pnb_src_t'($urandom_range(2));
    {A_WORD_HI, A_WORD_LO} = $urandom;
    {B_WORD_HI, B_WORD_LO} = $urandom;
    A_BITS = $urandom;
    B_BITS = $urandom;
    A_CONST = $urandom;
    B_CONST = $urandom;
    A_DIGITS = 4'($urandom_range(wide ? 8 : 4, 1));
    B_DIGITS = 4'($urandom_range(8, 1));
  endtask

  // holds reset for 12 cycles; all six outputs must read clear
  task automatic do_reset();
    OP_VALID = 1'b0;
    RST_N = 1'b0;
    repeat (12) @(negedge CLK_SYS);
    check({DONE, DEST_WE, DEST_DATA, RUNG_OUT, CMP_HIT, OP_ERR}, 0);
    RST_N = 1'b1;
    m_data = DATA_RST;
    m_rung = 1'b0;
    m_hit = 1'b0;
    m_slot = 16'h0000;
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    void'($urandom(32'h90d7));
    do_reset();
    EXEC_COND = 1'b1;
    for (int c = 1; c <= 5; c += 2) begin
      OP_CODE = pnb_op_t'(c);
      A_KIND = SRC_WORD;
      foreach (vals[i]) begin
        A_WORD_LO = vals[i];
        run();
      end
      for (int i = 0; i < 12; i++) begin
        rnd_opnds(1'b0);
        if (i[0]) A_WORD_LO = 16'($urandom_range(9999));
        // the last requests take bit operands so the digit counts really matter
        if (i > 7) A_KIND = SRC_BITS;
        if (i == 8) A_DIGITS = 4'h1;
        if (i > 9) A_DIGITS = (i == 10) ? 4'h0 : 4'h5;
        run();
      end
    end
    // refused requests with the condition off, including all pulse codes
    EXEC_COND = 1'b0;
    for (int c = 1; c <= 6; c++) begin
      OP_CODE = pnb_op_t'(c);
      run();
    end
    // pulse variants: only the off-to-on scan executes; plain ops leave the slot alone
    A_KIND = SRC_WORD;
    A_WORD_LO = 16'h0123;
    for (int c = 2; c <= 6; c += 2) begin
      OP_SLOT = 4'(c);
      for (int k = 0; k < 6; k++) begin
        OP_CODE = pnb_op_t'(k == 4 ? c - 1 : c);
        EXEC_COND = (k != 2) && (k != 4);
        run();
      end
    end
    do_reset();
    OP_CODE = OP_SIGN_INV_P;
    OP_SLOT = 4'h2;
    run();
    // every relation in every form, signed edges first, three equal pairs each
    OP_CODE = OP_CMP;
    for (int r = 0; r < 6; r++) begin
      for (int f = 0; f < 3; f++) begin
        for (int i = 0; i < 8; i++) begin
          CMP_REL = pnb_rel_t'(r);
          CMP_FORM = pnb_form_t'(f);
          RUNG_IN = i[0];
          rnd_opnds(1'b1);
          if (i < 4) begin
            A_KIND = SRC_CONST;
            B_KIND = SRC_CONST;
            A_CONST = edge_a[i];
            B_CONST = edge_b[i];
          end else if (i == 6) begin
            B_KIND = A_KIND;
            {B_WORD_HI, B_WORD_LO} = {A_WORD_HI, A_WORD_LO};
            B_BITS = A_BITS;
            B_DIGITS = A_DIGITS;
            B_CONST = A_CONST;
          end else if (i == 7) begin
            // word pair against an eight-unit bit image holding the same value
            A_KIND = SRC_WORD;
            B_KIND = SRC_BITS;
            B_DIGITS = 4'h8;
            B_BITS = {A_WORD_HI, A_WORD_LO};
          end
          run();
        end
      end
    end
    // a bad digit count on a load contact forces the contact open
    CMP_FORM = FORM_LOAD;
    A_KIND = SRC_BITS;
    A_DIGITS = 4'h9;
    run();
    OP_VALID = 1'b0;
    @(negedge CLK_SYS);
    check({DONE, DEST_WE, OP_ERR}, 0);
    tally_and_finish();
  end

  // watchdog: about 230 requests take some 13 us, so 1 ms means a hang
  initial begin
    #1000000;
    miscompares++;
    tally_and_finish();
  end
endmodule
